/* frame_irq.sv */
`timescale 1ns/1ps
// Sticky frame flag, write-one-to-clear, set wins over clear
module frame_irq (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Event and control
  input wire logic frame_start,
  input wire logic irq_enable,
  input wire logic clear_req,
  input wire logic mask_bit,
  // State
  output logic frame_irq_flag,
  output logic irq
);
  typedef struct packed {
    logic flag;
    logic irq;
  } st_t;
  st_t s_q;
  st_t s_d;

  always_comb begin
    s_d = s_q;
    if (frame_start && irq_enable) begin
      s_d.flag = 1'b1;
    end else if (clear_req) begin
      s_d.flag = 1'b0;
    end
    s_d.irq = s_d.flag & mask_bit;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign frame_irq_flag = s_q.flag;
  assign irq = s_q.irq;
endmodule

/* frame_src.sv */
`timescale 1ns/1ps
// Display glass side: one frame start pulse per frame
module frame_src #(
  parameter int PERIOD = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control and event
  input wire logic go,
  output logic frame_start
);
  int cnt_q;
  // Quiet while idle, so stale frames never leak into a test
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      frame_start <= 1'b0;
    end else begin
      cnt_q <= (go && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
      frame_start <= go && cnt_q == PERIOD - 1;
    end
  end
endmodule

/* lcd_ctrl_supply_regs.sv */
`timescale 1ns/1ps
module lcd_ctrl_supply_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [lcd_supply_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Processor power mode and display timing
  input wire logic cpu_in_wait,
  input wire logic cpu_in_stop,
  input wire logic frame_start,
  // Interrupt
  output logic irq,
  // Analog and pad steering
  output logic driver_run,
  output logic pump_run,
  output logic resistor_run,
  output logic pump_clk_en,
  output logic resistor_high_load,
  output logic third_bias_forced,
  output logic high_reference_select,
  output logic buffer_bypass,
  output logic [1:0] supply_config,
  output logic regulator_on,
  output logic gpio_push_pull,
  output logic gpio_ref_third_level
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl_sec;
    logic [7:0] supply;
    logic [7:0] core;
    logic irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic [1:0] resp;
    logic driver_run;
    logic pump_run;
    logic resistor_run;
    logic pump_clk_en;
    logic res_high;
    logic forced;
    logic high_ref;
    logic bypass;
    logic [1:0] sup;
    logic reg_on;
    logic push_pull;
    logic ref_third;
  } st_t;
  st_t s_q;
  st_t s_d;

  logic wr_hit;
  logic rd_hit;
  logic clear_req;
  logic flag;
  logic irq_w;
  logic pump_tick;
  logic halted;

  // Map an offset to its implemented byte mask; unmapped and OFF_IRQ_MASK give zero
  function automatic logic [7:0] reg_mask(input logic [lcd_supply_pkg::ADDR_W-1:0] a);
    case (a)
      lcd_supply_pkg::OFF_CTRL_SEC: reg_mask = lcd_supply_pkg::MASK_CTRL_SEC;
      lcd_supply_pkg::OFF_SUPPLY: reg_mask = lcd_supply_pkg::MASK_SUPPLY;
      lcd_supply_pkg::OFF_CORE: reg_mask = lcd_supply_pkg::MASK_CORE;
      lcd_supply_pkg::OFF_IRQ_STAT: reg_mask = lcd_supply_pkg::MASK_IRQ;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic mapped(input logic [lcd_supply_pkg::ADDR_W-1:0] a);
    mapped = (a == lcd_supply_pkg::OFF_CTRL_SEC) || (a == lcd_supply_pkg::OFF_SUPPLY) ||
             (a == lcd_supply_pkg::OFF_CORE) || (a == lcd_supply_pkg::OFF_IRQ_STAT) ||
             (a == lcd_supply_pkg::OFF_IRQ_MASK);
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle per access keeps read data registered; writes land at the ready edge
  assign wr_hit = avs_write && s_q.ack;
  assign rd_hit = avs_read && !s_q.ack;
  assign clear_req = wr_hit && avs_byteenable[0] && (avs_address == lcd_supply_pkg::OFF_IRQ_STAT)
                     && avs_writedata[lcd_supply_pkg::B_FRAME_FLAG];
  assign halted = (cpu_in_wait && s_q.ctrl_sec[lcd_supply_pkg::B_HALT_WAIT]) ||
                  (cpu_in_stop && s_q.ctrl_sec[lcd_supply_pkg::B_HALT_STOP]);

  always_comb begin
    logic [7:0] m;
    logic [7:0] wd;
    logic cp;
    logic drv;
    m = reg_mask(avs_address);
    wd = avs_writedata[7:0] & m;
    cp = s_q.supply[lcd_supply_pkg::B_BIAS_SRC];
    drv = s_q.core[lcd_supply_pkg::B_DRV_EN] && !halted;
    s_d = s_q;
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    s_d.resp = 2'h0;
    if ((avs_read || avs_write) && !s_q.ack && !mapped(avs_address)) begin
      s_d.resp = 2'h3;
    end
    // Register writes, accepted at any time
    if (wr_hit && avs_byteenable[0]) begin
      case (avs_address)
        lcd_supply_pkg::OFF_CTRL_SEC: s_d.ctrl_sec = wd;
        lcd_supply_pkg::OFF_SUPPLY: s_d.supply = wd;
        lcd_supply_pkg::OFF_CORE: s_d.core = wd;
        lcd_supply_pkg::OFF_IRQ_MASK: s_d.irq_mask = avs_writedata[0];
        default: s_d = s_d;
      endcase
    end
    // Registered read mux; unmapped and reserved read as zero
    s_d.rdata = 32'h0000_0000;
    if (rd_hit) begin
      case (avs_address)
        lcd_supply_pkg::OFF_CTRL_SEC: s_d.rdata[7:0] = s_q.ctrl_sec;
        lcd_supply_pkg::OFF_SUPPLY: s_d.rdata[7:0] = s_q.supply;
        lcd_supply_pkg::OFF_CORE: s_d.rdata[7:0] = s_q.core;
        lcd_supply_pkg::OFF_IRQ_STAT: s_d.rdata[0] = flag;
        lcd_supply_pkg::OFF_IRQ_MASK: s_d.rdata[0] = s_q.irq_mask;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Analog steering
    s_d.driver_run = drv;
    s_d.pump_run = drv && cp;
    s_d.resistor_run = drv && !cp;
    s_d.pump_clk_en = pump_tick && drv && cp;
    s_d.res_high = !cp && s_q.supply[lcd_supply_pkg::B_LOAD_ADJUST_HI];
    s_d.forced = 1'b1;
    s_d.high_ref = s_q.supply[lcd_supply_pkg::B_HIGH_REF];
    s_d.bypass = s_q.supply[lcd_supply_pkg::B_BYPASS];
    s_d.sup = s_q.supply[lcd_supply_pkg::B_SUP_HI:lcd_supply_pkg::B_SUP_LO];
    s_d.reg_on = s_q.core[lcd_supply_pkg::B_REG_EN] && cp;
    // Pad mode: push-pull only with full supply config and regulator off
    s_d.push_pull = s_q.ctrl_sec[lcd_supply_pkg::B_FULL_DRIVE] &&
                    (s_d.sup == lcd_supply_pkg::SUP_L3_EXTERNAL) &&
                    !s_q.core[lcd_supply_pkg::B_REG_EN];
    s_d.ref_third = s_d.push_pull;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.ctrl_sec <= lcd_supply_pkg::RST_CTRL_SEC;
      s_q.supply <= lcd_supply_pkg::RST_SUPPLY;
      s_q.core <= lcd_supply_pkg::RST_CORE;
      s_q.forced <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Pump clock only runs while the pump is live, saving power
  pump_clk_gen u_pump (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(s_q.pump_run),
    .rate_code(s_q.supply[lcd_supply_pkg::B_LOAD_ADJUST_HI:lcd_supply_pkg::B_LOAD_ADJUST_LO]),
    .pump_tick(pump_tick)
  );

  frame_irq u_irq (
    .core_clk(core_clk),
    .rstn(rstn),
    .frame_start(frame_start && s_q.driver_run),
    .irq_enable(s_q.ctrl_sec[lcd_supply_pkg::B_FRAME_IRQ_EN]),
    .clear_req(clear_req),
    .mask_bit(s_q.irq_mask),
    .frame_irq_flag(flag),
    .irq(irq_w)
  );

  // Outputs straight from flip-flops, except avs_waitrequest
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_response = s_q.resp;
  assign irq = irq_w;
  assign driver_run = s_q.driver_run;
  assign pump_run = s_q.pump_run;
  assign resistor_run = s_q.resistor_run;
  assign pump_clk_en = s_q.pump_clk_en;
  assign resistor_high_load = s_q.res_high;
  assign third_bias_forced = s_q.forced;
  assign high_reference_select = s_q.high_ref;
  assign buffer_bypass = s_q.bypass;
  assign supply_config = s_q.sup;
  assign regulator_on = s_q.reg_on;
  assign gpio_push_pull = s_q.push_pull;
  assign gpio_ref_third_level = s_q.ref_third;
endmodule

/* lcd_ctrl_supply_regs_sva.sv */
`timescale 1ns/1ps
module supply_regs_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Steering
  input wire logic pump_run,
  input wire logic resistor_run,
  input wire logic pump_clk_en,
  input wire logic resistor_high_load,
  input wire logic third_bias_forced,
  input wire logic [1:0] supply_config,
  input wire logic regulator_on,
  input wire logic gpio_push_pull,
  input wire logic gpio_ref_third_level
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // --------------------------------
  // Bus answer: one wait cycle, then ready
  // --------------------------------
  sequence s_ans;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (($rose(avs_read) || $rose(avs_write)) |-> s_ans)
    else $error("waitrequest not high then low");
  a_unmapped_zero: assert property ((avs_read && !avs_waitrequest && avs_address == 4'h2)
    |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  // --------------------------------
  // Bias and pad steering
  // --------------------------------
  a_pump_excl: assert property (pump_run |-> !resistor_run)
    else $error("pump and resistor both run");
  a_third_forced: assert property (third_bias_forced)
    else $error("one-third bias dropped");
  a_tick_gap: assert property (pump_clk_en |=> !pump_clk_en)
    else $error("pump ticks closer than two cycles");
  a_load_excl: assert property (resistor_high_load |-> !pump_run)
    else $error("resistor load set with pump bias");
  a_gpio_cond: assert property (gpio_push_pull |-> supply_config == 2'h3 && !regulator_on)
    else $error("push-pull without its conditions");
  a_gpio_ref: assert property (gpio_push_pull == gpio_ref_third_level)
    else $error("pad drive and reference disagree");
endmodule

bind lcd_ctrl_supply_regs supply_regs_chk i_chk (.core_clk(core_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .pump_run(pump_run), .resistor_run(resistor_run), .pump_clk_en(pump_clk_en),
  .resistor_high_load(resistor_high_load), .third_bias_forced(third_bias_forced),
  .supply_config(supply_config), .regulator_on(regulator_on), .gpio_push_pull(gpio_push_pull),
  .gpio_ref_third_level(gpio_ref_third_level));

/* lcd_supply_pkg.sv */
package lcd_supply_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each except OFF_IRQ_MASK at 4'h1)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL_SEC = 4'h0;
  localparam logic [3:0] OFF_SUPPLY = 4'h4;
  localparam logic [3:0] OFF_CORE = 4'h8;
  localparam logic [3:0] OFF_IRQ_STAT = 4'hc;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h1;
  localparam int ADDR_W = 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_FRAME_IRQ_EN = 7;
  localparam int B_FULL_DRIVE = 2;
  localparam int B_HALT_WAIT = 1;
  localparam int B_HALT_STOP = 0;
  localparam int B_BIAS_SRC = 7;
  localparam int B_HIGH_REF = 6;
  localparam int B_LOAD_ADJUST_HI = 5;
  localparam int B_LOAD_ADJUST_LO = 4;
  localparam int B_BYPASS = 2;
  localparam int B_SUP_HI = 1;
  localparam int B_SUP_LO = 0;
  localparam int B_DRV_EN = 7;
  localparam int B_REG_EN = 6;
  localparam int B_FRAME_FLAG = 0;

  // Writable bits per register
  localparam logic [7:0] MASK_CTRL_SEC = 8'h87;
  localparam logic [7:0] MASK_SUPPLY = 8'hf7;
  localparam logic [7:0] MASK_CORE = 8'hc0;
  localparam logic [7:0] MASK_IRQ = 8'h01;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_SEC = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_CORE = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;

  // Supply configuration codes
  localparam logic [1:0] SUP_L2_FROM_VDD = 2'h0;
  localparam logic [1:0] SUP_L3_FROM_VDD = 2'h1;
  localparam logic [1:0] SUP_L1_FROM_LCD = 2'h2;
  localparam logic [1:0] SUP_L3_EXTERNAL = 2'h3;

  // Charge pump clock: divider counter width and base value, shifted per load adjust code
  localparam int PUMP_DIV_W = 4;
  localparam logic [PUMP_DIV_W-1:0] PUMP_DIV_FAST = 4'h1;
endpackage

/* pump_clk_gen.sv */
`timescale 1ns/1ps
// Charge pump clock enable: code 00 fastest, 11 slowest
module pump_clk_gen #(
  parameter int DIV_W = lcd_supply_pkg::PUMP_DIV_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_code,
  // Enable out
  output logic pump_tick
);
  typedef struct packed {
    logic [DIV_W+2:0] cnt;
    logic tick;
  } st_t;
  st_t s_q;
  st_t s_d;
  logic [DIV_W+2:0] limit;

  // Each slower code doubles the period
  always_comb begin
    // Shift amount widened first, so code 11 cannot wrap to a zero shift
    limit = (DIV_W+3)'(({{(DIV_W-1){1'b0}}, lcd_supply_pkg::PUMP_DIV_FAST} << ({1'b0, rate_code} + 3'd1)) - 1);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= limit) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pump_tick = s_q.tick;
endmodule

/* tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic cpu_in_wait = 1'b0, cpu_in_stop = 1'b0, go = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic [1:0] avs_response, r, supply_config;
  logic avs_waitrequest, frame_start, irq, driver_run, pump_run, resistor_run, pump_clk_en;
  logic resistor_high_load, third_bias_forced, high_reference_select, buffer_bypass;
  logic regulator_on, gpio_push_pull, gpio_ref_third_level;
  int fails = 0, num_checks = 0;
  lcd_ctrl_supply_regs i_dut (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response,
    .cpu_in_wait, .cpu_in_stop, .frame_start, .irq, .driver_run, .pump_run, .resistor_run,
    .pump_clk_en, .resistor_high_load, .third_bias_forced, .high_reference_select,
    .buffer_bypass, .supply_config, .regulator_on, .gpio_push_pull, .gpio_ref_third_level);
  frame_src i_glass (.core_clk, .rstn, .go, .frame_start);
  // Clock, 4 ns period
  always #2 core_clk = ~core_clk;
  // --------------------------------
  // Bus tasks and helpers
  // --------------------------------
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    `CHK("bus ready", 1'b0, avs_waitrequest)
    d = avs_readdata;
    r = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    acc(1'b1, a, v);
  endtask
  // Outputs lag their cause by one cycle
  task automatic st();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic t_regs();
    logic [3:0] am[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h1};
    foreach (am[i]) begin
      acc(1'b0, am[i], 8'h0);
      `CHK("reset value", 32'h0, d)
    end
    `CHK("bias forced", 1'b1, third_bias_forced)
    wr(4'h0, 8'hff);
    acc(1'b0, 4'h0, 8'h0);
    `CHK("ctrl bits", 32'h87, d)
    wr(4'h4, 8'hff);
    acc(1'b0, 4'h4, 8'h0);
    `CHK("supply bits", 32'hf7, d)
    wr(4'h2, 8'hff);
    acc(1'b0, 4'h2, 8'h0);
    `CHK("unmapped resp", 2'h3, r)
    `CHK("unmapped data", 32'h0, d)
    wr(4'h0, 8'h04);
  endtask
  // Supply codes and pad drive; driver stays off meanwhile
  task automatic t_gpio();
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, 8'(c));
      st();
      `CHK("supply code", 2'(c), supply_config)
      `CHK("push pull", c == 3, gpio_push_pull)
      `CHK("third ref", c == 3, gpio_ref_third_level)
    end
    wr(4'h8, 8'h40);
    st();
    `CHK("regulator blocks", 1'b0, gpio_push_pull)
    `CHK("regulator off", 1'b0, regulator_on)
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h00);
    st();
    `CHK("open drain", 1'b0, gpio_ref_third_level)
  endtask
  task automatic t_bias();
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {2'b01, 2'(c), 4'h4});
      st();
      `CHK("high load", c >= 2, resistor_high_load)
      `CHK("high ref", 1'b1, high_reference_select)
      `CHK("bypass", 1'b1, buffer_bypass)
    end
    wr(4'h4, 8'h80);
    st();
    `CHK("divided ref", 1'b0, high_reference_select)
    `CHK("buffered", 1'b0, buffer_bypass)
  endtask
  // Halt bits against wait and stop, pump bias selected
  task automatic t_halt();
    wr(4'h8, 8'hc0);
    st();
    `CHK("driver on", 1'b1, driver_run)
    `CHK("resistor off", 1'b0, resistor_run)
    `CHK("regulator on", 1'b1, regulator_on)
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 8'(m));
      for (int k = 0; k < 2; k++) begin
        @(posedge core_clk);
        cpu_in_wait <= (k == 0);
        cpu_in_stop <= (k == 1);
        st();
        `CHK("run in mode", k ? !m[0] : !m[1], driver_run)
        `CHK("pump in mode", k ? !m[0] : !m[1], pump_run)
      end
    end
    @(posedge core_clk);
    cpu_in_stop <= 1'b0;
  endtask
  task automatic t_pump();
    int t;
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, {2'b10, 2'(c), 4'h0});
      t = 0;
      do begin
        @(posedge core_clk);
        #1;
        t++;
      end while (!pump_clk_en && t < 40);
      t = 0;
      do begin
        @(posedge core_clk);
        #1;
        t++;
      end while (!pump_clk_en && t < 40);
      `CHK("pump period", 1 << (c + 1), t)
    end
  endtask
  task automatic t_irq();
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h01);
    @(posedge core_clk);
    go <= 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
    `CHK("irq raised", 1'b1, irq)
    wr(4'h1, 8'h00);
    st();
    `CHK("irq masked", 1'b0, irq)
    @(posedge core_clk);
    go <= 1'b0;
    acc(1'b0, 4'hc, 8'h0);
    `CHK("flag held", 32'h1, d)
    wr(4'hc, 8'h01);
    acc(1'b0, 4'hc, 8'h0);
    `CHK("flag cleared", 32'h0, d)
    wr(4'h0, 8'h00);
    go <= 1'b1;
    repeat (30) @(posedge core_clk);
    go <= 1'b0;
    acc(1'b0, 4'hc, 8'h0);
    `CHK("no flag", 32'h0, d)
    wr(4'h8, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_gpio();
    t_bias();
    t_halt();
    t_pump();
    t_irq();
    tally_and_finish();
  end
  // Watchdog, several times the expected run
  initial begin
    #40000;
    fails++;
    $display("FAIL watchdog expired");
    tally_and_finish();
  end
endmodule
